// >>> verilog/sync_clamp_pkg.sv
/*
 Constants, register layouts and timing counts for the sync, clamp
 and output control register slice of the video digitizer.
 Assumes a 25 MHz system clock that also samples the serial bus pins.
*/
package sync_clamp_pkg;

   // Serial bus slave address; the value is arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h4C;

   localparam logic [7:0] ADDR_PLL_CLAMP = 8'h0F;
   localparam logic [7:0] ADDR_DRIVE = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h11;

   // Bit 7 down to bit 0 of the PLL and clamp control register
   typedef struct packed {
      logic hsPolHigh;
      logic coastPolHigh;
      logic clampExt;
      logic clampPolHigh;
      logic extClkBypass;
      logic [2:0] clampMid;
   } pll_clamp_s;

   typedef struct packed {
      logic [1:0] rsvdHi;
      logic [1:0] drive;
      logic hiz;
      logic syncDtPolHigh;
      logic [1:0] rsvdLo;
   } drive_s;

   typedef struct packed {
      logic hsDet;
      logic sogDet;
      logic vsDet;
      logic dclkDet;
      logic actAnalog;
      logic actSog;
      logic actSep;
      logic rsvd;
   } status_s;

   localparam logic [7:0] RST_PLL_CLAMP = 8'hD0;
   localparam logic [7:0] RST_DRIVE = 8'h34;
   localparam logic [7:0] DRIVE_WMASK = 8'h3C;

   localparam logic [1:0] DRV_LOW = 2'h0;
   localparam logic [1:0] DRV_MED = 2'h1;
   localparam logic [1:0] DRV_HIGH = 2'h2;

   localparam int CLK_MHZ = 25;
   localparam int HS_TIMEOUT_US = 100;
   localparam int VS_TIMEOUT_US = 40000;
   localparam int DCLK_TIMEOUT_US = 1;
   localparam int POL_WINDOW_US = 1000;
   localparam int HS_TIMEOUT_CYC = HS_TIMEOUT_US * CLK_MHZ;
   localparam int VS_TIMEOUT_CYC = VS_TIMEOUT_US * CLK_MHZ;
   localparam int DCLK_TIMEOUT_CYC = DCLK_TIMEOUT_US * CLK_MHZ;
   localparam int POL_WINDOW_CYC = POL_WINDOW_US * CLK_MHZ;

   localparam int CNT_W = 21;
   localparam int NUM_DET = 4;

endpackage

// >>> verilog/activity_detect.sv
/*
 Activity detector: reports presence of toggling on one input.
 Assumes the input is synchronous to clk.
*/
`timescale 1ns/1ps
module activity_detect
#(
   parameter int TIMEOUT = 2500
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Watched signal
   input wire logic sig,
   // Presence flag
   output logic present
);

   localparam int W = sync_clamp_pkg::CNT_W;
   localparam logic [W-1:0] LIMIT = W'(TIMEOUT - 1);

   logic sigPrev_ff;
   logic present_ff;
   logic [W-1:0] cnt_ff;
   logic nxt_sigPrev;
   logic nxt_present;
   logic [W-1:0] nxt_cnt;

   // Any edge restarts the quiet timer; presence drops after TIMEOUT
   always_comb
   begin
      nxt_sigPrev = sig;
      nxt_present = present_ff;
      nxt_cnt = cnt_ff;
      if (sig != sigPrev_ff)
      begin
         nxt_cnt = '0;
         nxt_present = 1'b1;
      end
      else if (cnt_ff == LIMIT)
      begin
         nxt_present = 1'b0;
      end
      else
      begin
         nxt_cnt = cnt_ff + W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sigPrev_ff <= 1'b0;
         present_ff <= 1'b0;
         cnt_ff <= '0;
      end
      else
      begin
         sigPrev_ff <= nxt_sigPrev;
         present_ff <= nxt_present;
         cnt_ff <= nxt_cnt;
      end
   end

   assign present = present_ff;

endmodule

// >>> verilog/sync_clamp_control_status_regs.sv
/*
 Two-wire serial slave with the PLL and clamp control, output drive
 control and sync detect status registers, plus the sync, clamp and
 source selection logic they steer.
 Assumes scl, sdaIn and all video inputs are synchronous to clk and
 that scl is slow against clk (at least four clk cycles per level).
*/
`timescale 1ns/1ps
module sync_clamp_control_status_regs
#(
   parameter int HS_TIMEOUT_CYC = sync_clamp_pkg::HS_TIMEOUT_CYC,
   parameter int VS_TIMEOUT_CYC = sync_clamp_pkg::VS_TIMEOUT_CYC,
   parameter int DCLK_TIMEOUT_CYC = sync_clamp_pkg::DCLK_TIMEOUT_CYC,
   parameter int POL_WINDOW_CYC = sync_clamp_pkg::POL_WINDOW_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Two-wire serial bus
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Video timing inputs
   input wire logic hsyncIn,
   input wire logic sogIn,
   input wire logic vsyncIn,
   input wire logic digClkIn,
   input wire logic coastIn,
   input wire logic clampIn,
   // Override controls
   input wire logic intfOverride,
   input wire logic intfSelectDigital,
   input wire logic hsyncPolOverride,
   input wire logic hsyncSrcOverride,
   input wire logic hsyncSrcSog,
   input wire logic vsyncSrcOverride,
   input wire logic vsyncSrcSep,
   // Conditioned controls
   output logic hsyncPos,
   output logic coastPos,
   output logic clampPos,
   output logic externalClockBypass,
   output logic pllEnable,
   output logic [2:0] clampMidscale,
   output logic [1:0] driveSel,
   output logic dataOe,
   output logic syncDetectOutput,
   output logic activeAnalog,
   output logic hsyncFromSog,
   output logic vsyncFromSep
);

   localparam int W = sync_clamp_pkg::CNT_W;
   localparam int ND = sync_clamp_pkg::NUM_DET;
   localparam logic [W-1:0] POL_LAST = W'(POL_WINDOW_CYC - 1);
   localparam logic [W-1:0] POL_HALF = W'(POL_WINDOW_CYC / 2);

   typedef enum {
      ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK,
      ST_WR, ST_WACK, ST_RD, ST_MACK
   } bus_state_e;

   function automatic int timeoutFor(input int idx);
      case (idx)
         0, 1: timeoutFor = HS_TIMEOUT_CYC;
         2: timeoutFor = VS_TIMEOUT_CYC;
         default: timeoutFor = DCLK_TIMEOUT_CYC;
      endcase
   endfunction

   sync_clamp_pkg::pll_clamp_s pllClamp_ff;
   sync_clamp_pkg::drive_s drive_ff;
   sync_clamp_pkg::status_s status_ff;
   sync_clamp_pkg::pll_clamp_s nxt_pllClamp;
   sync_clamp_pkg::drive_s nxt_drive;
   sync_clamp_pkg::status_s nxt_status;

   function automatic logic [7:0] readByte(input logic [7:0] addr);
      case (addr)
         sync_clamp_pkg::ADDR_PLL_CLAMP: readByte = pllClamp_ff;
         sync_clamp_pkg::ADDR_DRIVE:
            readByte = drive_ff & sync_clamp_pkg::DRIVE_WMASK;
         sync_clamp_pkg::ADDR_STATUS: readByte = status_ff;
         default: readByte = 8'h00;
      endcase
   endfunction

   // Activity detectors: hsync, sync on green, vsync, digital clock
   logic [ND-1:0] detIn;
   logic [ND-1:0] det;
   assign detIn = {digClkIn, vsyncIn, sogIn, hsyncIn};

   genvar gi;
   generate
      for (gi = 0; gi < ND; gi++)
      begin : g_det
         activity_detect #(.TIMEOUT(timeoutFor(gi))) u_det
         (
            .clk(clk),
            .rst_n(rst_n),
            .sig(detIn[gi]),
            .present(det[gi])
         );
      end
   endgenerate

   // Serial bus slave
   bus_state_e state_ff;
   bus_state_e nxt_state;
   logic sclPrev_ff;
   logic sdaPrev_ff;
   logic [7:0] shift_ff;
   logic [3:0] bitCnt_ff;
   logic [7:0] ptr_ff;
   logic rw_ff;
   logic nack_ff;
   logic sdaOe_ff;
   logic [7:0] nxt_shift;
   logic [3:0] nxt_bitCnt;
   logic [7:0] nxt_ptr;
   logic nxt_rw;
   logic nxt_nack;
   logic nxt_sdaOe;
   logic wrStb;
   logic [7:0] rdByte;

   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   assign sclRise = scl && !sclPrev_ff;
   assign sclFall = !scl && sclPrev_ff;
   assign startCond = scl && sclPrev_ff && sdaPrev_ff && !sdaIn;
   assign stopCond = scl && sclPrev_ff && !sdaPrev_ff && sdaIn;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_ptr = ptr_ff;
      nxt_rw = rw_ff;
      nxt_nack = nack_ff;
      nxt_sdaOe = sdaOe_ff;
      wrStb = 1'b0;
      rdByte = readByte(ptr_ff);
      if (startCond)
      begin
         nxt_state = ST_ADDR;
         nxt_bitCnt = 4'h0;
         nxt_sdaOe = 1'b0;
      end
      else if (stopCond)
      begin
         nxt_state = ST_IDLE;
         nxt_sdaOe = 1'b0;
      end
      else if (sclRise)
      begin
         case (state_ff)
            ST_ADDR, ST_REG, ST_WR:
            begin
               nxt_shift = {shift_ff[6:0], sdaIn};
               nxt_bitCnt = bitCnt_ff + 4'h1;
            end
            ST_RD: nxt_bitCnt = bitCnt_ff + 4'h1;
            ST_MACK: nxt_nack = sdaIn;
            default: nxt_state = state_ff;
         endcase
      end
      else if (sclFall)
      begin
         case (state_ff)
            ST_ADDR:
               if (bitCnt_ff == 4'h8)
               begin
                  if (shift_ff[7:1] == sync_clamp_pkg::DEV_ADDR)
                  begin
                     nxt_state = ST_AACK;
                     nxt_rw = shift_ff[0];
                     nxt_sdaOe = 1'b1;
                  end
                  else
                  begin
                     nxt_state = ST_IDLE;
                  end
               end
            ST_AACK, ST_MACK:
            begin
               nxt_bitCnt = 4'h0;
               if (state_ff == ST_MACK && nack_ff)
               begin
                  nxt_state = ST_IDLE;
                  nxt_sdaOe = 1'b0;
               end
               else if (state_ff == ST_MACK || rw_ff)
               begin
                  nxt_state = ST_RD;
                  nxt_shift = rdByte;
                  nxt_sdaOe = !rdByte[7];
               end
               else
               begin
                  nxt_state = ST_REG;
                  nxt_sdaOe = 1'b0;
               end
            end
            ST_REG:
               if (bitCnt_ff == 4'h8)
               begin
                  nxt_ptr = shift_ff;
                  nxt_state = ST_RACK;
                  nxt_sdaOe = 1'b1;
               end
            ST_WR:
               if (bitCnt_ff == 4'h8)
               begin
                  wrStb = 1'b1;
                  nxt_state = ST_WACK;
                  nxt_sdaOe = 1'b1;
               end
            ST_RACK, ST_WACK:
            begin
               if (state_ff == ST_WACK)
               begin
                  nxt_ptr = ptr_ff + 8'h01;
               end
               nxt_state = ST_WR;
               nxt_bitCnt = 4'h0;
               nxt_sdaOe = 1'b0;
            end
            ST_RD:
               if (bitCnt_ff == 4'h8)
               begin
                  nxt_state = ST_MACK;
                  nxt_ptr = ptr_ff + 8'h01;
                  nxt_sdaOe = 1'b0;
               end
               else
               begin
                  nxt_sdaOe = !shift_ff[6];
                  nxt_shift = {shift_ff[6:0], 1'b0};
               end
            default: nxt_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_IDLE;
         sclPrev_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
         shift_ff <= 8'h00;
         bitCnt_ff <= 4'h0;
         ptr_ff <= 8'h00;
         rw_ff <= 1'b0;
         nack_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         sclPrev_ff <= scl;
         sdaPrev_ff <= sdaIn;
         shift_ff <= nxt_shift;
         bitCnt_ff <= nxt_bitCnt;
         ptr_ff <= nxt_ptr;
         rw_ff <= nxt_rw;
         nack_ff <= nxt_nack;
         sdaOe_ff <= nxt_sdaOe;
      end
   end

   // Registers; the status byte is rebuilt every cycle
   always_comb
   begin
      nxt_pllClamp = pllClamp_ff;
      nxt_drive = drive_ff;
      if (wrStb && ptr_ff == sync_clamp_pkg::ADDR_PLL_CLAMP)
      begin
         nxt_pllClamp = shift_ff;
      end
      if (wrStb && ptr_ff == sync_clamp_pkg::ADDR_DRIVE)
      begin
         nxt_drive = shift_ff & sync_clamp_pkg::DRIVE_WMASK;
      end
      nxt_status.hsDet = det[0];
      nxt_status.sogDet = det[1];
      nxt_status.vsDet = det[2];
      nxt_status.dclkDet = det[3];
      nxt_status.actAnalog = det[0] || det[1];
      nxt_status.actSog = det[1] && !det[0];
      nxt_status.actSep = !det[2];
      nxt_status.rsvd = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pllClamp_ff <= sync_clamp_pkg::RST_PLL_CLAMP;
         drive_ff <= sync_clamp_pkg::RST_DRIVE;
         status_ff <= 8'h00;
      end
      else
      begin
         pllClamp_ff <= nxt_pllClamp;
         drive_ff <= nxt_drive;
         status_ff <= nxt_status;
      end
   end

   // Automatic hsync polarity: the shorter level is the pulse
   logic [W-1:0] winCnt_ff;
   logic [W-1:0] hiCnt_ff;
   logic autoPolHigh_ff;
   logic [W-1:0] nxt_winCnt;
   logic [W-1:0] nxt_hiCnt;
   logic nxt_autoPolHigh;
   logic rawHs;
   logic hsPolHigh;
   logic syncDet;

   always_comb
   begin
      nxt_autoPolHigh = autoPolHigh_ff;
      nxt_winCnt = winCnt_ff + W'(1);
      nxt_hiCnt = hiCnt_ff + W'(rawHs);
      if (winCnt_ff == POL_LAST)
      begin
         nxt_autoPolHigh = hiCnt_ff < POL_HALF;
         nxt_winCnt = '0;
         nxt_hiCnt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         winCnt_ff <= '0;
         hiCnt_ff <= '0;
         autoPolHigh_ff <= 1'b0;
      end
      else
      begin
         winCnt_ff <= nxt_winCnt;
         hiCnt_ff <= nxt_hiCnt;
         autoPolHigh_ff <= nxt_autoPolHigh;
      end
   end

   // Source selection and conditioned outputs
   logic nxt_hsyncFromSog;
   logic nxt_vsyncFromSep;
   logic nxt_activeAnalog;
   logic [1:0] nxt_driveSel;
   logic hsyncPos_ff;
   logic coastPos_ff;
   logic clampPos_ff;
   logic external_clock_bypass_ff;
   logic pllEn_ff;
   logic [2:0] clampMid_ff;
   logic [1:0] driveSel_ff;
   logic dataOe_ff;
   logic syncDtOut_ff;
   logic actAnalog_ff;
   logic hsSog_ff;
   logic vsSep_ff;

   always_comb
   begin
      nxt_hsyncFromSog = hsyncSrcOverride ? hsyncSrcSog : status_ff.actSog;
      nxt_vsyncFromSep = vsyncSrcOverride ? vsyncSrcSep : status_ff.actSep;
      nxt_activeAnalog = intfOverride ? !intfSelectDigital
                                      : status_ff.actAnalog;
      rawHs = hsSog_ff ? sogIn : hsyncIn;
      hsPolHigh = hsyncPolOverride ? pllClamp_ff.hsPolHigh : autoPolHigh_ff;
      syncDet = status_ff.hsDet || status_ff.sogDet;
      case (drive_ff.drive)
         2'b11, 2'b10: nxt_driveSel = sync_clamp_pkg::DRV_HIGH;
         2'b01: nxt_driveSel = sync_clamp_pkg::DRV_MED;
         default: nxt_driveSel = sync_clamp_pkg::DRV_LOW;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hsyncPos_ff <= 1'b0;
         coastPos_ff <= 1'b0;
         clampPos_ff <= 1'b0;
         external_clock_bypass_ff <= 1'b0;
         pllEn_ff <= 1'b1;
         clampMid_ff <= 3'h0;
         driveSel_ff <= sync_clamp_pkg::DRV_HIGH;
         dataOe_ff <= 1'b0;
         syncDtOut_ff <= 1'b0;
         actAnalog_ff <= 1'b0;
         hsSog_ff <= 1'b0;
         vsSep_ff <= 1'b0;
      end
      else
      begin
         hsyncPos_ff <= rawHs ^ !hsPolHigh;
         coastPos_ff <= coastIn ^ !pllClamp_ff.coastPolHigh;
         clampPos_ff <= pllClamp_ff.clampExt
                        ? clampIn ^ !pllClamp_ff.clampPolHigh
                        : rawHs ^ !hsPolHigh;
         external_clock_bypass_ff <= pllClamp_ff.extClkBypass;
         pllEn_ff <= !pllClamp_ff.extClkBypass;
         clampMid_ff <= pllClamp_ff.clampMid;
         driveSel_ff <= nxt_driveSel;
         dataOe_ff <= !drive_ff.hiz;
         syncDtOut_ff <= syncDet ^ !drive_ff.syncDtPolHigh;
         actAnalog_ff <= nxt_activeAnalog;
         hsSog_ff <= nxt_hsyncFromSog;
         vsSep_ff <= nxt_vsyncFromSep;
      end
   end

   // Open-drain data line only ever pulls low
   logic sdaOut_ff;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sdaOut_ff <= 1'b0;
      end
      else
      begin
         sdaOut_ff <= 1'b0;
      end
   end

   assign sdaOut = sdaOut_ff;
   assign sdaOe = sdaOe_ff;
   assign hsyncPos = hsyncPos_ff;
   assign coastPos = coastPos_ff;
   assign clampPos = clampPos_ff;
   assign externalClockBypass = external_clock_bypass_ff;
   assign pllEnable = pllEn_ff;
   assign clampMidscale = clampMid_ff;
   assign driveSel = driveSel_ff;
   assign dataOe = dataOe_ff;
   assign syncDetectOutput = syncDtOut_ff;
   assign activeAnalog = actAnalog_ff;
   assign hsyncFromSog = hsSog_ff;
   assign vsyncFromSep = vsSep_ff;

endmodule

// >>> tb/sync_clamp_asserts.sv
/*
 Checker for the sync, clamp and drive register slice, bound to its top.
 Sees only top ports; expects scl to hold each level several clocks.
*/
`timescale 1ns/1ps
module sync_clamp_asserts
#(
   parameter int HS_TIMEOUT_CYC = 50, parameter int VS_TIMEOUT_CYC = 200,
   parameter int DCLK_TIMEOUT_CYC = 8, parameter int POL_WINDOW_CYC = 64
)
(
   // Clock, reset and bus clock
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   // Inputs watched
   input wire logic hsyncIn,
   input wire logic vsyncIn,
   input wire logic coastIn,
   input wire logic intfOverride,
   input wire logic intfSelectDigital,
   input wire logic hsyncSrcOverride,
   input wire logic hsyncSrcSog,
   input wire logic vsyncSrcOverride,
   // Outputs checked
   input wire logic pllEnable,
   input wire logic externalClockBypass,
   input wire logic [1:0] driveSel,
   input wire logic dataOe,
   input wire logic [2:0] clampMidscale,
   input wire logic coastPos,
   input wire logic activeAnalog,
   input wire logic hsyncFromSog,
   input wire logic vsyncFromSep
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic [2:0] age_ff;
   logic [2:0] nxt_age;
   logic [2:0] sclHist_ff;
   logic [2:0] nxt_sclHist;
   logic quiet;
   always_comb
   begin
      nxt_age = age_ff + {2'h0, ~&age_ff};
      nxt_sclHist = {sclHist_ff[1:0], scl};
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         age_ff <= 3'h0;
         sclHist_ff <= 3'h0;
      end
      else
      begin
         age_ff <= nxt_age;
         sclHist_ff <= nxt_sclHist;
      end
   end
   // Registers move only after an scl fall, so a long high level is quiet
   assign quiet = (&age_ff) & scl & (&sclHist_ff);

   pll_enable_a:
   assert property (pllEnable == !externalClockBypass)
      else $error("pll enable and bypass disagree");
   drive_code_a:
   assert property (driveSel != 2'h3)
      else $error("drive select out of range");
   coast_follow_a:
   assert property (quiet && $changed(coastIn) |=> $changed(coastPos))
      else $error("coast output ignored an input change");
   intf_override_a:
   assert property (age_ff[2] && $past(intfOverride)
      |-> activeAnalog == !$past(intfSelectDigital))
      else $error("active interface ignores override");
   hsync_active_a:
   assert property (($changed(hsyncIn) && !intfOverride) ##1
      !intfOverride [*4] |-> activeAnalog)
      else $error("hsync activity did not mark analog active");
   vsync_active_a:
   assert property (($changed(vsyncIn) && !vsyncSrcOverride) ##1
      !vsyncSrcOverride [*4] |-> !vsyncFromSep)
      else $error("vsync activity did not select the pin");
   hsrc_override_a:
   assert property (age_ff[2] && $past(hsyncSrcOverride)
      |-> hsyncFromSog == $past(hsyncSrcSog))
      else $error("hsync source ignores override");
   clamp_hold_a:
   assert property (quiet |=> $stable(clampMidscale))
      else $error("clamp level moved without a write");
   drive_hold_a:
   assert property (quiet |=> $stable({driveSel, dataOe}))
      else $error("drive control moved without a write");

   cover property (quiet && $changed(coastIn));
   cover property ($fell(dataOe));
   cover property ($rose(activeAnalog));
endmodule

bind sync_clamp_control_status_regs sync_clamp_asserts #(
   .HS_TIMEOUT_CYC(HS_TIMEOUT_CYC), .VS_TIMEOUT_CYC(VS_TIMEOUT_CYC),
   .DCLK_TIMEOUT_CYC(DCLK_TIMEOUT_CYC), .POL_WINDOW_CYC(POL_WINDOW_CYC)
) chk (
   .clk(clk), .rst_n(rst_n), .scl(scl), .hsyncIn(hsyncIn),
   .vsyncIn(vsyncIn), .coastIn(coastIn), .intfOverride(intfOverride),
   .intfSelectDigital(intfSelectDigital),
   .hsyncSrcOverride(hsyncSrcOverride), .hsyncSrcSog(hsyncSrcSog),
   .vsyncSrcOverride(vsyncSrcOverride), .pllEnable(pllEnable),
   .externalClockBypass(externalClockBypass), .driveSel(driveSel),
   .dataOe(dataOe), .clampMidscale(clampMidscale), .coastPos(coastPos),
   .activeAnalog(activeAnalog), .hsyncFromSog(hsyncFromSog),
   .vsyncFromSep(vsyncFromSep));

// >>> tb/serial_host.sv
/*
 Behavioural two-wire bus master for the register slice bench.
 Assumes the bench builds an open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
module serial_host
(
   // Clock
   input wire logic clk,
   // Bus wires
   input wire logic sdaWire,
   output logic scl,
   output logic sdaDrv
);
   initial
   begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   // Levels last six or more clocks, above the slave's minimum of four
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic start_cond();
      wait_clk(2);
      sdaDrv = 1'b1;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(6);
      sdaDrv = 1'b0;
      wait_clk(6);
      scl = 1'b0;
   endtask
   task automatic stop_cond();
      wait_clk(2);
      sdaDrv = 1'b0;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(6);
      sdaDrv = 1'b1;
      wait_clk(6);
   endtask
   // Data moves only while scl is low; a 1 releases the wire
   task automatic xfer_bit(input logic b, output logic r);
      wait_clk(2);
      sdaDrv = b;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(6);
      r = sdaWire;
      scl = 1'b0;
   endtask
   task automatic xfer_byte(input logic [7:0] d, input logic ackIn,
      output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--)
         xfer_bit(d[i], r[i]);
      xfer_bit(ackIn, ack);
   endtask
endmodule

// >>> tb/sync_clamp_control_status_regs_bench.sv
/*
 Self-checking bench for the sync, clamp and drive register slice.
 Inputs change on the falling clock edge; the host model runs the bus.
*/
`timescale 1ns/1ps
`define CHECK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module sync_clamp_control_status_regs_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic scl, sdaDrv, sdaIn, sdaOut, sdaOe;
   logic hsyncIn = 1'b0, sogIn = 1'b0, vsyncIn = 1'b0, digClkIn = 1'b0;
   logic coastIn = 1'b0, clampIn = 1'b0, polOvr = 1'b0;
   logic [5:0] ovr = 6'h00;
   logic [3:0] runs = 4'h0;
   logic hsyncPos, coastPos, clampPos, externalClockBypass, pllEnable;
   logic dataOe, syncDetectOutput, activeAnalog, hsyncFromSog, vsyncFromSep;
   logic [2:0] clampMidscale;
   logic [1:0] driveSel;
   int cyc = 0;
   int fails = 0;
   int tests_run = 0;

   assign sdaIn = sdaDrv & ~sdaOe;
   serial_host host (.clk(clk), .sdaWire(sdaIn), .scl(scl), .sdaDrv(sdaDrv));
   sync_clamp_control_status_regs #(.HS_TIMEOUT_CYC(50),
      .VS_TIMEOUT_CYC(200), .DCLK_TIMEOUT_CYC(8), .POL_WINDOW_CYC(64)) dut (
      .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .hsyncIn(hsyncIn), .sogIn(sogIn), .vsyncIn(vsyncIn),
      .digClkIn(digClkIn), .coastIn(coastIn), .clampIn(clampIn),
      .intfOverride(ovr[5]), .intfSelectDigital(ovr[4]),
      .hsyncPolOverride(polOvr), .hsyncSrcOverride(ovr[3]),
      .hsyncSrcSog(ovr[2]), .vsyncSrcOverride(ovr[1]), .vsyncSrcSep(ovr[0]),
      .hsyncPos(hsyncPos), .coastPos(coastPos), .clampPos(clampPos),
      .externalClockBypass(externalClockBypass), .pllEnable(pllEnable),
      .clampMidscale(clampMidscale), .driveSel(driveSel), .dataOe(dataOe),
      .syncDetectOutput(syncDetectOutput), .activeAnalog(activeAnalog),
      .hsyncFromSog(hsyncFromSog), .vsyncFromSep(vsyncFromSep));

   initial
   begin
      forever #20 clk = ~clk;
   end

   // Activity sources toggle well inside the shortened detector timeouts
   always @(negedge clk)
   begin
      cyc <= cyc + 1;
      hsyncIn <= runs[3] & cyc[2];
      sogIn <= runs[2] & cyc[2];
      vsyncIn <= runs[1] & cyc[3];
      digClkIn <= runs[0] & cyc[0];
      if (cyc == 40000)
      begin
         fails++;
         close_out();
      end
   end

   task automatic close_out();
      if (fails == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic reg_ptr(input logic [7:0] ptr);
      logic [7:0] r;
      logic a;
      host.start_cond();
      host.xfer_byte({sync_clamp_pkg::DEV_ADDR, 1'b0}, 1'b1, r, a);
      `CHECK(a, 1'b0)
      host.xfer_byte(ptr, 1'b1, r, a);
      `CHECK(a, 1'b0)
   endtask
   task automatic reg_write(input logic [7:0] ptr, input logic [15:0] d,
      input int n);
      logic [7:0] r;
      logic a;
      reg_ptr(ptr);
      for (int i = n - 1; i >= 0; i--)
      begin
         host.xfer_byte(d[8*i +: 8], 1'b1, r, a);
         `CHECK(a, 1'b0)
      end
      host.stop_cond();
   endtask
   task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d);
      logic a;
      reg_ptr(ptr);
      host.start_cond();
      host.xfer_byte({sync_clamp_pkg::DEV_ADDR, 1'b1}, 1'b1, d, a);
      `CHECK(a, 1'b0)
      host.xfer_byte(8'hFF, 1'b1, d, a);
      host.stop_cond();
   endtask

   initial
   begin
      logic [7:0] pats [5];
      logic [3:0] acts [4];
      logic [7:0] v, e, p, r;
      logic [1:0] f, ds;
      logic a;
      pats = '{8'h2F, 8'hD0, 8'h78, 8'h95, 8'h42};
      acts = '{4'hF, 4'h4, 4'h9, 4'h0};
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      host.wait_clk(2);
      `CHECK(pllEnable, 1'b1)
      `CHECK(driveSel, sync_clamp_pkg::DRV_HIGH)
      `CHECK(sdaOut, 1'b0)
      reg_read(sync_clamp_pkg::ADDR_PLL_CLAMP, v);
      `CHECK(v, sync_clamp_pkg::RST_PLL_CLAMP)
      reg_read(sync_clamp_pkg::ADDR_DRIVE, v);
      `CHECK(v, sync_clamp_pkg::RST_DRIVE)
      // Overrides win over what the detectors report
      runs = 4'hF;
      ovr = 6'h3F;
      host.wait_clk(20);
      `CHECK(activeAnalog, 1'b0)
      `CHECK(hsyncFromSog, 1'b1)
      `CHECK(vsyncFromSep, 1'b1)
      ovr = 6'h00;
      for (int k = 0; k < 4; k++)
      begin
         runs = acts[k];
         host.wait_clk(250);
         reg_read(sync_clamp_pkg::ADDR_STATUS, v);
         e = {acts[k], acts[k][3] | acts[k][2], acts[k][2] & !acts[k][3],
            !acts[k][1], 1'b0};
         `CHECK(v, e)
         `CHECK(activeAnalog, e[3])
         `CHECK(hsyncFromSog, e[2])
         `CHECK(vsyncFromSep, e[1])
         `CHECK(syncDetectOutput, e[3])
      end
      // Overrides with the selects low, against an idle auto result
      ovr = 6'h2A;
      host.wait_clk(3);
      `CHECK(activeAnalog, 1'b1)
      `CHECK(vsyncFromSep, 1'b0)
      // Refused address, read-only status and an unmapped place
      host.start_cond();
      host.xfer_byte({sync_clamp_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
      `CHECK(a, 1'b1)
      host.stop_cond();
      reg_write(sync_clamp_pkg::ADDR_STATUS, 16'h00FF, 1);
      reg_read(sync_clamp_pkg::ADDR_STATUS, v);
      `CHECK(v, 8'h02)
      reg_read(8'h20, v);
      `CHECK(v, 8'h00)
      coastIn = 1'b1;
      polOvr = 1'b1;
      foreach (pats[k])
      begin
         p = pats[k];
         clampIn = p[0];
         reg_write(sync_clamp_pkg::ADDR_PLL_CLAMP, {8'h00, p}, 1);
         reg_read(sync_clamp_pkg::ADDR_PLL_CLAMP, v);
         `CHECK(v, p)
         `CHECK(hsyncPos, !p[7])
         `CHECK(coastPos, p[6])
         `CHECK(clampPos, p[5] ? p[0] ~^ p[4] : !p[7])
         `CHECK(externalClockBypass, p[3])
         `CHECK(pllEnable, !p[3])
         `CHECK(clampMidscale, p[2:0])
      end
      coastIn = 1'b0;
      polOvr = 1'b0;
      host.wait_clk(3);
      `CHECK(coastPos, !p[6])
      `CHECK(hsyncPos, 1'b0)
      // Pointer advances to the drive register for the second byte
      reg_write(sync_clamp_pkg::ADDR_PLL_CLAMP, 16'h1508, 2);
      host.wait_clk(3);
      `CHECK(dataOe, 1'b0)
      `CHECK(driveSel, sync_clamp_pkg::DRV_LOW)
      `CHECK(syncDetectOutput, 1'b1)
      reg_read(sync_clamp_pkg::ADDR_DRIVE, v);
      `CHECK(v, 8'h08)
      for (int i = 0; i < 4; i++)
      begin
         f = i[1:0];
         ds = f[0] ? sync_clamp_pkg::DRV_MED : sync_clamp_pkg::DRV_LOW;
         ds = f[1] ? sync_clamp_pkg::DRV_HIGH : ds;
         reg_write(sync_clamp_pkg::ADDR_DRIVE, {10'h003, f, 4'h7}, 1);
         reg_read(sync_clamp_pkg::ADDR_DRIVE, v);
         `CHECK(v, {2'h0, f, 4'h4})
         `CHECK(driveSel, ds)
         `CHECK(dataOe, 1'b1)
         `CHECK(syncDetectOutput, 1'b0)
      end
      close_out();
   end
endmodule
